/* rfe_ctrl.sv */
// radio front end control: mode sequencer, registers, gain and tx settings
`timescale 1ns/100ps
`include "rfe_defs.svh"
`default_nettype none
module rfe_ctrl #(
  parameter int TICK_DIV_W = 16
) (
  input  wire logic          clk_sys,
  input  wire logic          nrst,
  input  wire rfe_pkg::cmd_t cmd,
  input  wire logic          cmd_valid,
  input  wire logic [15:0]   timeout_tick_count,
  input  wire logic [15:0]   timeout_tick_base,
  input  wire logic [4:0]    output_power_level,
  input  wire logic [4:0]    pa_ramp_duration,
  input  wire logic          power_ramp_valid,
  input  wire logic [23:0]   carrier_frequency_word,
  input  wire logic          carrier_valid,
  input  wire logic          packet_status_query,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  input  wire logic [11:0]   reg_addr,
  input  wire logic [7:0]    reg_wdata,
  output logic [7:0]         reg_rdata,
  input  wire logic          pkt_done_async,
  input  wire logic          pkt_rx_async,
  input  wire logic [7:0]    received_strength_value_in,
  input  wire logic [3:0]    agc_gain,
  output logic [7:0]         received_strength_value,
  output logic               busy,
  output rfe_pkg::mode_t     mode,
  output logic               standby_rc_oscillator,
  output logic               synth_only_mode,
  output logic               pa_enable,
  output logic [7:0]         pa_ramp_level,
  output logic               tx_packet,
  output logic               tx_tone,
  output logic               tx_alt_bits,
  output logic               rx_enable,
  output logic [5:0]         tx_power_code,
  output logic [23:0]        synth_word,
  output logic [3:0]         fe_gain,
  output logic [5:0]         gain_atten_db,
  output logic               high_sens
);
  import rfe_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] done_sy_r;
  logic [1:0] rx_sy_r;
  logic       done_d_r;
  logic       rx_d_r;
  logic       pkt_done;
  logic       pkt_rx;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      done_sy_r <= 2'h0;
      rx_sy_r   <= 2'h0;
      done_d_r  <= 1'b0;
      rx_d_r    <= 1'b0;
    end else begin
      done_sy_r <= {done_sy_r[0], pkt_done_async};
      rx_sy_r   <= {rx_sy_r[0], pkt_rx_async};
      done_d_r  <= done_sy_r[1];
      rx_d_r    <= rx_sy_r[1];
    end
  end
  assign pkt_done = done_sy_r[1] & ~done_d_r;
  assign pkt_rx   = rx_sy_r[1] & ~rx_d_r;

  //////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] sens_r, sens_nxt;
  logic [7:0] auto_r, auto_nxt;
  logic [7:0] lvl_r, lvl_nxt;
  logic [7:0] men_r, men_nxt;

  always_comb begin
    sens_nxt = sens_r;
    auto_nxt = auto_r;
    lvl_nxt  = lvl_r;
    men_nxt  = men_r;
    if (reg_wr) begin
      case (reg_addr)
        `REG_SENS_SELECT:    sens_nxt = reg_wdata; // R13
        `REG_GAIN_AUTO:      auto_nxt = reg_wdata; // R7
        `REG_MAN_GAIN_LEVEL: lvl_nxt  = reg_wdata; // R8
        `REG_MAN_GAIN_EN:    men_nxt  = reg_wdata; // R7
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sens_r <= 8'h00; // R12
      auto_r <= `GAIN_AUTO_RESET; // R6
      lvl_r  <= `GAIN_LEVEL_RESET;
      men_r  <= 8'h00; // R6
    end else begin
      sens_r <= sens_nxt;
      auto_r <= auto_nxt;
      lvl_r  <= lvl_nxt;
      men_r  <= men_nxt;
    end
  end

  logic [7:0] rdata_r, rdata_nxt;
  always_comb begin
    rdata_nxt = rdata_r;
    if (reg_rd) begin
      case (reg_addr)
        `REG_SENS_SELECT:    rdata_nxt = sens_r;
        `REG_GAIN_AUTO:      rdata_nxt = auto_r;
        `REG_MAN_GAIN_LEVEL: rdata_nxt = lvl_r;
        `REG_MAN_GAIN_EN:    rdata_nxt = men_r;
        default:             rdata_nxt = 8'h00;
      endcase
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end
  assign reg_rdata = rdata_r;

  //////////////////////////////////////////////////////////////////////////////
  // gain selection
  logic       hs;
  logic       manual;
  logic [3:0] g_raw;
  logic [3:0] g_sel;
  logic [5:0] atten;

  assign hs     = (sens_r[`SENS_FIELD_HI:`SENS_FIELD_LO] == `SENS_HIGH_VALUE); // R13
  assign manual = men_r[`MAN_EN_BIT] & ~auto_r[`AUTO_BIT]; // R6 R7
  assign g_raw  = manual ? lvl_r[3:0] : agc_gain; // R8

  always_comb begin
    g_sel = g_raw;
    if (g_sel == 4'h0) begin
      g_sel = 4'h1;
    end else if (g_sel > `GAIN_MAX_STEP) begin
      g_sel = `GAIN_MAX_STEP;
    end
    // low power keeps the three top steps out of reach
    if (!hs && g_sel > `GAIN_LP_TOP) begin
      g_sel = `GAIN_LP_TOP; // R12
    end
  end

  always_comb begin
    atten = 6'h00;
    if (g_sel >= 4'h9) begin
      atten = 6'((4'hD - g_sel) * 2); // R9
    end else if (g_sel == 4'h8) begin
      atten = 6'h0C; // R9
    end else begin
      atten = 6'(6'h12 + (4'h7 - g_sel) * 6); // R9
    end
  end

  logic [3:0] gain_r;
  logic [5:0] att_r;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      gain_r <= 4'h0;
      att_r  <= 6'h00;
    end else begin
      gain_r <= g_sel;
      att_r  <= atten;
    end
  end
  assign fe_gain       = gain_r;
  assign gain_atten_db = att_r;
  assign high_sens     = hs;

  //////////////////////////////////////////////////////////////////////////////
  // tx settings, carrier word, strength capture
  logic [5:0]  pwr_r, pwr_nxt;
  logic [4:0]  ramp_r, ramp_nxt;
  logic [23:0] freq_r, freq_nxt;
  logic [7:0]  received_strength_value_r, received_strength_value_nxt;
  logic [7:0]  rsv_r, rsv_nxt;

  always_comb begin
    pwr_nxt  = pwr_r;
    ramp_nxt = ramp_r;
    freq_nxt = freq_r;
    received_strength_value_nxt = received_strength_value_r;
    rsv_nxt  = rsv_r;
    if (power_ramp_valid) begin
      // code 31 is the final half step to the top level
      pwr_nxt = {1'b0, output_power_level}; // R3
      if (pa_ramp_duration < 5'(`RAMP_MIN_US)) begin
        ramp_nxt = 5'(`RAMP_MIN_US); // R4
      end else if (pa_ramp_duration > 5'(`RAMP_MAX_US)) begin
        ramp_nxt = 5'(`RAMP_MAX_US); // R4
      end else begin
        ramp_nxt = pa_ramp_duration;
      end
    end
    if (carrier_valid) begin
      freq_nxt = carrier_frequency_word; // R14
    end
    if (pkt_rx) begin
      received_strength_value_nxt = received_strength_value_in; // R11
    end
    if (packet_status_query) begin
      rsv_nxt = received_strength_value_r; // R11
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pwr_r  <= 6'h00;
      ramp_r <= 5'(`RAMP_MIN_US);
      freq_r <= `FREQ_WORD_RESET; // R15
      received_strength_value_r <= 8'h00;
      rsv_r  <= 8'h00;
    end else begin
      pwr_r  <= pwr_nxt;
      ramp_r <= ramp_nxt;
      freq_r <= freq_nxt;
      received_strength_value_r <= received_strength_value_nxt;
      rsv_r  <= rsv_nxt;
    end
  end
  assign tx_power_code           = pwr_r;
  assign synth_word              = freq_r;
  assign received_strength_value = rsv_r;

  //////////////////////////////////////////////////////////////////////////////
  // tick divider
  logic [TICK_DIV_W-1:0] div_r, div_nxt;
  logic                  tick;
  always_comb begin
    div_nxt = div_r + 1'b1;
    if (div_r >= timeout_tick_base) begin
      div_nxt = '0;
    end
  end
  assign tick = (div_r >= timeout_tick_base);
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      div_r <= '0;
    end else begin
      div_r <= div_nxt;
    end
  end

  rfe_timer_if tif ();
  rfe_timeout #(.CW(16)) u_tmo (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .tick    (tick),
    .tif     (tif)
  );

  //////////////////////////////////////////////////////////////////////////////
  // mode sequencer
  mode_t       st_r, st_nxt;
  mode_t       tgt_r, tgt_nxt;
  logic [15:0] cyc_r, cyc_nxt;
  logic [4:0]  us_r, us_nxt;
  logic        start_c;

  always_comb begin
    st_nxt  = st_r;
    tgt_nxt = tgt_r;
    cyc_nxt = cyc_r;
    us_nxt  = us_r;
    start_c = 1'b0;
    case (st_r)
      ST_STANDBY: begin
        if (cmd_valid) begin
          cyc_nxt = 16'h0000;
          case (cmd)
            CMD_TX: begin
              tgt_nxt = ST_RAMP;
              st_nxt  = ST_SYNTH; // R16
              start_c = 1'b1; // R2
            end
            CMD_RX: begin
              tgt_nxt = ST_RX;
              st_nxt  = ST_SYNTH; // R16
              start_c = 1'b1; // R10
            end
            CMD_TONE: begin
              tgt_nxt = ST_TONE;
              st_nxt  = ST_SYNTH;
            end
            CMD_ALT: begin
              tgt_nxt = ST_ALT;
              st_nxt  = ST_SYNTH;
            end
            CMD_SYNTH: begin
              tgt_nxt = ST_SYNTH;
              st_nxt  = ST_SYNTH; // R16
            end
            default: begin
            end
          endcase
        end
      end
      ST_SYNTH: begin
        if (cyc_r < 16'(`SYNTH_LOCK_CYC)) begin
          cyc_nxt = cyc_r + 1'b1;
        end else if (tgt_r != ST_SYNTH) begin
          st_nxt  = tgt_r;
          cyc_nxt = 16'h0000;
          us_nxt  = 5'h00;
        end
      end
      ST_RAMP: begin
        if (cyc_r == 16'(`RAMP_CYC_PER_US - 1)) begin
          cyc_nxt = 16'h0000;
          us_nxt  = us_r + 1'b1;
          if (us_nxt >= ramp_r) begin
            st_nxt = ST_TX; // R4
          end
        end else begin
          cyc_nxt = cyc_r + 1'b1;
        end
      end
      ST_TX: begin
        if (pkt_done) begin
          st_nxt = ST_STANDBY; // R1 R2
        end
      end
      ST_RX: begin
      end
      ST_TONE, ST_ALT: begin
      end
      default: begin
        st_nxt = ST_STANDBY;
      end
    endcase
    // timeout reaches every timed state, including synth and ramp on the way
    if (tif.expired && (tgt_r == ST_RAMP || tgt_r == ST_RX) && st_r != ST_STANDBY) begin
      st_nxt = ST_STANDBY; // R2 R10
    end
    if (cmd_valid && cmd == CMD_STOP) begin
      st_nxt = ST_STANDBY;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_r  <= ST_STANDBY;
      tgt_r <= ST_STANDBY;
      cyc_r <= 16'h0000;
      us_r  <= 5'h00;
    end else begin
      st_r  <= st_nxt;
      tgt_r <= tgt_nxt;
      cyc_r <= cyc_nxt;
      us_r  <= us_nxt;
    end
  end

  assign tif.start = start_c;
  assign tif.stop  = (st_nxt == ST_STANDBY) && (st_r != ST_STANDBY);
  assign tif.count = timeout_tick_count;

  logic [7:0] rl_r;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rl_r <= 8'h00;
    end else if (st_r == ST_RAMP) begin
      // widen before the product, an 8 bit product wraps for long ramps
      rl_r <= 8'((16'(us_r) * 16'h00FF) / 16'((ramp_r == 5'h00) ? 5'h01 : ramp_r)); // R4
    end else if (st_r == ST_TX || st_r == ST_TONE || st_r == ST_ALT) begin
      rl_r <= 8'hFF;
    end else begin
      rl_r <= 8'h00;
    end
  end

  assign mode                  = st_r;
  assign busy                  = (st_r == ST_SYNTH) || (st_r == ST_RAMP);
  assign standby_rc_oscillator = (st_r == ST_STANDBY);
  assign synth_only_mode       = (st_r == ST_SYNTH);
  assign pa_enable             = (st_r == ST_RAMP) || (st_r == ST_TX) ||
                                 (st_r == ST_TONE) || (st_r == ST_ALT);
  assign pa_ramp_level         = rl_r;
  assign tx_packet             = (st_r == ST_TX); // R1
  assign tx_tone               = (st_r == ST_TONE); // R5
  assign tx_alt_bits           = (st_r == ST_ALT); // R5
  assign rx_enable             = (st_r == ST_RX); // R10
endmodule
`default_nettype wire

/* rfe_defs.svh */
// constants for the radio front end control block
// How it works
// R1 - transmit command sends the buffered packet with the configured modulation
// R2 - after transmit, back to rc standby on packet end or timeout
// R3 - output power is code minus 18 dBm, top step half a dB
// R4 - pa supply ramps over a programmable 2 to 20 us before sending
// R5 - tone test and alternating bits test transmit modes exist
// R6 - automatic gain active after reset until software disables it
// R7 - host writes manual_gain_enable bit7 and clears gain_control_auto_select bit0 for manual gain
// R8 - manual gain in bits 3:0 of manual_gain_level, values 1 to 13
// R9 - manual gain setting maps to attenuation below maximum per table
// R10 - receive command enters receive, timeout returns to rc standby
// R11 - strength value captured on packet reception, returned on status query
// R12 - low power receive at reset blocks the top three gain steps
// R13 - writing 3 to bits 7:6 of receive_sensitivity_select enables high sensitivity
// R14 - carrier is 52 MHz over 2^18 times the 24-bit word
// R15 - reset frequency word gives a 2.4 GHz carrier
// R16 - synth only mode on command, and passed through entering tx or rx
// R17 - timeout counter advances per base tick, expires at programmed count
`ifndef RFE_DEFS_SVH
`define RFE_DEFS_SVH
`define REG_SENS_SELECT     12'h891
`define REG_GAIN_AUTO       12'h895
`define REG_MAN_GAIN_LEVEL  12'h89E
`define REG_MAN_GAIN_EN     12'h89F
`define SENS_FIELD_HI       7
`define SENS_FIELD_LO       6
`define SENS_HIGH_VALUE     2'h3
`define AUTO_BIT            0
`define MAN_EN_BIT          7
`define GAIN_AUTO_RESET     8'h01
`define GAIN_LEVEL_RESET    8'h0D
`define FREQ_WORD_RESET     24'hB89D8A
`define POWER_OFFSET_DB     18
`define RAMP_MIN_US         2
`define RAMP_MAX_US         20
`define CLK_MHZ             50
`define RAMP_CYC_PER_US     `CLK_MHZ
`define SYNTH_LOCK_US       1
`define SYNTH_LOCK_CYC      (`SYNTH_LOCK_US * `CLK_MHZ)
`define GAIN_MAX_STEP       4'hD
`define GAIN_LP_TOP         4'hA
`endif

/* rfe_pkg.sv */
// types shared by the radio front end control modules
`default_nettype none
package rfe_pkg;
  typedef enum logic [2:0] {
    ST_STANDBY = 3'b000,
    ST_SYNTH   = 3'b001,
    ST_RAMP    = 3'b010,
    ST_TX      = 3'b011,
    ST_RX      = 3'b100,
    ST_TONE    = 3'b101,
    ST_ALT     = 3'b110
  } mode_t;
  typedef enum logic [2:0] {
    CMD_NONE  = 3'h0,
    CMD_TX    = 3'h1,
    CMD_RX    = 3'h2,
    CMD_SYNTH = 3'h3,
    CMD_TONE  = 3'h4,
    CMD_ALT   = 3'h5,
    CMD_STOP  = 3'h6
  } cmd_t;
endpackage
`default_nettype wire

/* rfe_timer_if.sv */
// interface between the mode sequencer and the timeout counter
`timescale 1ns/100ps
`default_nettype none
interface rfe_timer_if;
  logic        start;
  logic        stop;
  logic [15:0] count;
  logic        expired;
  modport ctrl (output start, output stop, output count, input expired);
  modport tmr  (input start, input stop, input count, output expired);
endinterface
`default_nettype wire

/* rfe_timeout.sv */
// timeout counter advancing once per tick enable
`timescale 1ns/100ps
`default_nettype none
module rfe_timeout #(
  parameter int CW = 16
) (
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic tick,
  rfe_timer_if.tmr  tif
);
  logic          run_r;
  logic          run_nxt;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          exp_r;
  logic          exp_nxt;

  always_comb begin
    run_nxt = run_r;
    cnt_nxt = cnt_r;
    exp_nxt = 1'b0;
    if (tif.stop) begin
      run_nxt = 1'b0;
    end else if (tif.start) begin
      // a count of zero means no timeout
      run_nxt = (tif.count != '0);
      cnt_nxt = '0;
    end else if (run_r && tick) begin
      cnt_nxt = cnt_r + 1'b1; // R17
      if (cnt_nxt == tif.count) begin
        exp_nxt = 1'b1; // R17
        run_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      run_r <= 1'b0;
      cnt_r <= '0;
      exp_r <= 1'b0;
    end else begin
      run_r <= run_nxt;
      cnt_r <= cnt_nxt;
      exp_r <= exp_nxt;
    end
  end

  assign tif.expired = exp_r;
endmodule
`default_nettype wire

/* rfe_ctrl_checker.sv */
// concurrent checks on the ports of the radio front end control block
`timescale 1ns/100ps
`default_nettype none
module rfe_ctrl_checker (
  input wire logic           clk_sys,
  input wire logic           nrst,
  input wire rfe_pkg::cmd_t  cmd,
  input wire logic           cmd_valid,
  input wire logic           reg_wr,
  input wire logic [11:0]    reg_addr,
  input wire logic [7:0]     reg_wdata,
  input wire logic [23:0]    carrier_frequency_word,
  input wire logic           carrier_valid,
  input wire rfe_pkg::mode_t mode,
  input wire logic           standby_rc_oscillator,
  input wire logic           synth_only_mode,
  input wire logic           tx_packet,
  input wire logic           tx_tone,
  input wire logic           tx_alt_bits,
  input wire logic [23:0]    synth_word,
  input wire logic [3:0]     fe_gain,
  input wire logic [5:0]     gain_atten_db,
  input wire logic           high_sens
);
  import rfe_pkg::*;
  logic [1:0] wsens;
  assign wsens = reg_wdata[7:6];
  function automatic logic [5:0] atten_of(input logic [3:0] g);
    return 6'(g >= 4'h9 ? (13 - g) * 2 : (g == 4'h8 ? 12 : 18 + (7 - g) * 6));
  endfunction
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////////
  // a command to synth-only keeps the synthesizer on, so only tx/rx/tone/alt entries leave
  sequence synth_dwell;
    synth_only_mode throughout ##50 1'b1;
  endsequence
  sequence synth_leave;
    ##1 !synth_only_mode;
  endsequence
  a_cmd_to_synth: assert property (
    cmd_valid && mode == ST_STANDBY && cmd inside {CMD_TX, CMD_RX, CMD_SYNTH, CMD_TONE, CMD_ALT}
    |=> mode == ST_SYNTH) else $error("command did not enter synth");
  a_synth_dwell: assert property (
    $rose(synth_only_mode) && $past(cmd) != CMD_SYNTH |-> synth_dwell ##0 synth_leave)
    else $error("synth dwell length wrong");
  a_low_power_cap: assert property (
    !high_sens [*3] |-> fe_gain <= 4'hA) else $error("gain above low power cap");
  a_gain_map: assert property (
    $stable(fe_gain) [*2] ##0 fe_gain inside {[4'h1:4'hD]} |-> gain_atten_db == atten_of(fe_gain))
    else $error("gain attenuation mismatch");
  a_sens_decode: assert property (
    reg_wr && reg_addr == 12'h891 |=> high_sens == ($past(wsens) == 2'h3))
    else $error("high sensitivity decode wrong");
  a_carrier_load: assert property (
    carrier_valid |=> synth_word == $past(carrier_frequency_word))
    else $error("carrier word not loaded");
  a_stop_standby: assert property (
    cmd_valid && cmd == CMD_STOP |=> standby_rc_oscillator) else $error("stop left standby");
  a_test_holds: assert property (
    (tx_tone || tx_alt_bits) && !(cmd_valid && cmd == CMD_STOP) |=> $stable(mode))
    else $error("test mode left without stop");
  a_tx_after_ramp: assert property (
    $rose(tx_packet) |-> $past(mode) == ST_RAMP) else $error("transmit without ramp");
endmodule
bind rfe_ctrl rfe_ctrl_checker chk_u (.clk_sys(clk_sys), .nrst(nrst), .cmd(cmd),
  .cmd_valid(cmd_valid), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .carrier_frequency_word(carrier_frequency_word), .carrier_valid(carrier_valid),
  .mode(mode), .standby_rc_oscillator(standby_rc_oscillator),
  .synth_only_mode(synth_only_mode), .tx_packet(tx_packet), .tx_tone(tx_tone),
  .tx_alt_bits(tx_alt_bits), .synth_word(synth_word), .fe_gain(fe_gain),
  .gain_atten_db(gain_atten_db), .high_sens(high_sens));
`default_nettype wire

/* rfe_radio_model.sv */
// model of the modem side: packet end, packet arrival, strength and agc gain
`timescale 1ns/100ps
`default_nettype none
module rfe_radio_model (
  input wire logic  clk_sys,
  output logic       pkt_done_async,
  output logic       pkt_rx_async,
  output logic [7:0] received_strength_value_in,
  output logic [3:0] agc_gain
);
  initial begin
    pkt_done_async = 1'b0;
    pkt_rx_async = 1'b0;
    received_strength_value_in = 8'h00;
    agc_gain = 4'h7;
  end
  // pulses are off the clock edge on purpose, these pins are asynchronous
  task automatic end_packet();
    @(posedge clk_sys);
    #7 pkt_done_async = 1'b1;
    repeat (3) @(posedge clk_sys);
    #7 pkt_done_async = 1'b0;
  endtask
  // strength held past the sync latency, then scrambled so a late sample shows
  task automatic rx_packet(input logic [7:0] lvl);
    @(posedge clk_sys);
    #7 received_strength_value_in = lvl;
    pkt_rx_async = 1'b1;
    repeat (3) @(posedge clk_sys);
    #7 pkt_rx_async = 1'b0;
    repeat (4) @(posedge clk_sys);
    #7 received_strength_value_in = ~lvl;
  endtask
endmodule
`default_nettype wire

/* tb.sv */
// testbench for the radio front end control block
`timescale 1ns/100ps
`default_nettype none
module tb;
  import rfe_pkg::*;
  logic clk_sys, nrst, cmd_valid, power_ramp_valid, carrier_valid, packet_status_query;
  logic reg_wr, reg_rd, pkt_done_async, pkt_rx_async, busy, standby_rc_oscillator;
  logic synth_only_mode, pa_enable, tx_packet, tx_tone, tx_alt_bits, rx_enable, high_sens;
  logic [15:0] timeout_tick_count, timeout_tick_base;
  logic [4:0]  output_power_level, pa_ramp_duration;
  logic [23:0] carrier_frequency_word, synth_word;
  logic [11:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, received_strength_value_in, received_strength_value, pa_ramp_level;
  logic [3:0]  agc_gain, fe_gain;
  logic [5:0]  tx_power_code, gain_atten_db;
  cmd_t        cmd;
  mode_t       mode;
  int          num_errors = 0;
  int          checked = 0;
  rfe_ctrl #(.TICK_DIV_W(16)) dut_u (.*);
  rfe_radio_model model_u (.*);
  always #10 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_mode(input mode_t exp);
    checked++;
    if (mode !== exp) begin
      num_errors++;
      $display("FAIL mode expected %h seen %h", exp, mode);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic send(input cmd_t c);
    @(negedge clk_sys);
    cmd = c;
    cmd_valid = 1'b1;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    chk("reg_rdata", 24'(exp), 24'(reg_rdata));
  endtask
  // timeout 100 ticks of 2 cycles lands at about 200 cycles after the command
  task automatic tx_case(input bit early);
    send(CMD_TX);
    cyc(149);
    chk_mode(ST_RAMP);
    chk("busy", 24'h1, 24'(busy));
    chk("pa_enable", 24'h1, 24'(pa_enable));
    chk("ramp_level", 24'h7F, 24'(pa_ramp_level));
    cyc(9);
    chk("tx_packet", 24'h1, 24'(tx_packet));
    chk("ramp_level", 24'hFF, 24'(pa_ramp_level));
    chk("busy", 24'h0, 24'(busy));
    if (early) begin
      model_u.end_packet();
      cyc(10);
      chk("standby", 24'h1, 24'(standby_rc_oscillator));
    end else begin
      cyc(15);
      chk("tx_packet", 24'h1, 24'(tx_packet));
      cyc(40);
      chk("standby", 24'h1, 24'(standby_rc_oscillator));
    end
    $display("test tx early=%0d done", early);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  logic [11:0] ra[5] = '{12'h891, 12'h895, 12'h89E, 12'h89F, 12'h123};
  logic [7:0]  rv[5] = '{8'h00, 8'h01, 8'h0D, 8'h00, 8'h00};
  logic [3:0]  gl[4] = '{4'h1, 4'h5, 4'h8, 4'h9};
  logic [5:0]  ga[4] = '{6'd54, 6'd30, 6'd12, 6'd8};
  cmd_t        tc[2] = '{CMD_TONE, CMD_ALT};
  mode_t       tm[2] = '{ST_TONE, ST_ALT};
  initial begin
    clk_sys = 1'b0;
    nrst = 1'b0;
    {cmd_valid, power_ramp_valid, carrier_valid, packet_status_query, reg_wr, reg_rd} = '0;
    cmd = CMD_NONE;
    timeout_tick_count = 16'h0064;
    timeout_tick_base = 16'h0001;
    {output_power_level, pa_ramp_duration, reg_addr, reg_wdata} = '0;
    carrier_frequency_word = 24'h000000;
    cyc(8);
    nrst = 1'b1;
    cyc(2);
    chk_mode(ST_STANDBY);
    chk("synth_word", 24'hB89D8A, synth_word);
    chk("fe_gain", 24'h7, 24'(fe_gain));
    for (int i = 0; i < 5; i++) rd(ra[i], rv[i]);
    $display("test reset done");
    wr(12'h89F, 8'h80);
    wr(12'h895, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(12'h89E, 8'(gl[i]));
      cyc(3);
      chk("fe_gain", 24'(gl[i]), 24'(fe_gain));
      chk("atten", 24'(ga[i]), 24'(gain_atten_db));
    end
    wr(12'h89E, 8'h0D);
    cyc(3);
    chk("fe_gain", 24'hA, 24'(fe_gain));
    wr(12'h891, 8'hC0);
    cyc(3);
    chk("high_sens", 24'h1, 24'(high_sens));
    chk("atten", 24'h0, 24'(gain_atten_db));
    rd(12'h891, 8'hC0);
    wr(12'h895, 8'h01);
    cyc(3);
    chk("fe_gain", 24'h7, 24'(fe_gain));
    @(negedge clk_sys);
    carrier_frequency_word = 24'h5A5A5A;
    carrier_valid = 1'b1;
    @(negedge clk_sys);
    carrier_valid = 1'b0;
    chk("synth_word", 24'h5A5A5A, synth_word);
    $display("test registers done");
    send(CMD_RX);
    chk("synth", 24'h1, 24'(synth_only_mode));
    cyc(50);
    chk("synth", 24'h1, 24'(synth_only_mode));
    cyc(1);
    chk("rx_enable", 24'h1, 24'(rx_enable));
    model_u.rx_packet(8'h3C);
    send(CMD_TONE);
    chk_mode(ST_RX);
    @(negedge clk_sys);
    packet_status_query = 1'b1;
    @(negedge clk_sys);
    packet_status_query = 1'b0;
    chk("strength", 24'h3C, 24'(received_strength_value));
    cyc(115);
    chk("rx_enable", 24'h1, 24'(rx_enable));
    cyc(32);
    chk("standby", 24'h1, 24'(standby_rc_oscillator));
    $display("test rx done");
    @(negedge clk_sys);
    output_power_level = 5'd30;
    pa_ramp_duration = 5'd2;
    power_ramp_valid = 1'b1;
    @(negedge clk_sys);
    power_ramp_valid = 1'b0;
    cyc(1);
    chk("power", 24'd30, 24'(tx_power_code));
    tx_case(1'b1);
    tx_case(1'b0);
    for (int i = 0; i < 2; i++) begin
      send(tc[i]);
      cyc(60);
      chk_mode(tm[i]);
      cyc(40);
      chk_mode(tm[i]);
      send(CMD_STOP);
      chk_mode(ST_STANDBY);
    end
    send(CMD_SYNTH);
    cyc(80);
    chk("synth", 24'h1, 24'(synth_only_mode));
    send(CMD_STOP);
    $display("test modes done");
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
